// >>> include/aid_map.vh
// Purpose: opcode values, decode field codes and widths for the decoder
// Assumes: an 8-bit opcode fetched a byte at a time from program memory
// Notes:   ranges of eight are named by opcode[7:3], of two by opcode[7:1]
`ifndef AID_MAP_VH
`define AID_MAP_VH

// Field widths
`define AID_FN_W    5
`define AID_KD_W    4
`define AID_LEN_W   2
`define AID_CYC_W   2
`define AID_DEC_W   17

// Single opcodes, full byte
`define OP_ADD_DIR  8'h25
`define OP_ADC_DIR  8'h35
`define OP_SBB_DIR  8'h95
`define OP_ADD_IMM  8'h24
`define OP_ADC_IMM  8'h34
`define OP_SBB_IMM  8'h94
`define OP_ANL_DI   8'h53
`define OP_ORL_DI   8'h43
`define OP_XRL_DI   8'h63
`define OP_ANL_DA   8'h52
`define OP_ORL_DA   8'h42
`define OP_XRL_DA   8'h62
`define OP_ANL_DIR  8'h55
`define OP_ORL_DIR  8'h45
`define OP_XRL_DIR  8'h65
`define OP_ANL_IMM  8'h54
`define OP_ORL_IMM  8'h44
`define OP_XRL_IMM  8'h64
`define OP_RL       8'h23
`define OP_RLC      8'h33
`define OP_RR       8'h03
`define OP_RRC      8'h13
`define OP_MOV_DD   8'h85
`define OP_MOV_DIMM 8'h75
`define OP_MOV_ADIR 8'hE5
`define OP_MOV_DIRA 8'hF5
`define OP_DPL      8'h90
`define OP_CRD_DP   8'h93
`define OP_CRD_PC   8'h83
`define OP_XRD_DP   8'hE0
`define OP_XWR_DP   8'hF0
`define OP_PUSH     8'hC0
`define OP_POP      8'hD0
`define OP_XCH_DIR  8'hC5

// Bank register ranges, opcode[7:3]
`define RG_ADD      5'h05
`define RG_ADC      5'h07
`define RG_SBB      5'h13
`define RG_ANL      5'h0B
`define RG_ORL      5'h09
`define RG_XRL      5'h0D
`define RG_LD_DIR   5'h15
`define RG_ST_DIR   5'h11
`define RG_LD_IMM   5'h0F
`define RG_TO_A     5'h1D
`define RG_FROM_A   5'h1F
`define RG_XCH      5'h19

// Indirect pointer pairs, opcode[7:1]
`define PR_ADD      7'h13
`define PR_ADC      7'h1B
`define PR_SBB      7'h4B
`define PR_ANL      7'h2B
`define PR_ORL      7'h23
`define PR_XRL      7'h33
`define PR_LD_A     7'h73
`define PR_ST_A     7'h7B
`define PR_ST_DIR   7'h53
`define PR_ST_IMM   7'h3B
`define PR_TO_DIR   7'h43
`define PR_XRD      7'h71
`define PR_XWR      7'h79
`define PR_XCH      7'h63

// Operation codes
`define FN_NOP      5'h00
`define FN_ADD      5'h01
`define FN_ADC      5'h02
`define FN_SBB      5'h03
`define FN_AND      5'h04
`define FN_OR       5'h05
`define FN_XOR      5'h06
`define FN_RL       5'h07
`define FN_RLC      5'h08
`define FN_RR       5'h09
`define FN_RRC      5'h0A
`define FN_MOV      5'h0B
`define FN_XCH      5'h0C
`define FN_PUSH     5'h0D
`define FN_POP      5'h0E
`define FN_CRD      5'h0F
`define FN_XRD      5'h10
`define FN_XWR      5'h11
`define FN_DPL      5'h12

// Operand kinds
`define K_NONE      4'h0
`define K_ACC       4'h1
`define K_REG       4'h2
`define K_DIR       4'h3
`define K_IND       4'h4
`define K_IMM       4'h5
`define K_CDP       4'h6
`define K_EXT8      4'h7
`define K_EXT16     4'h8
`define K_STK       4'h9
`define K_DPR       4'hA
`define K_IMM16     4'hB
`define K_CPC       4'hC

// Lengths and cycle counts
`define L0          2'h0
`define L1          2'h1
`define L2          2'h2
`define L3          2'h3
`define C1          2'h1
`define C2          2'h2

`endif

// >>> src/aid_fields.v
// Purpose: pull register and pointer selects out of an opcode
// Assumes: opcode is stable while its select is used
// Notes:   purely combinational, no state
`timescale 1ns/100ps
`default_nettype none
module aid_fields (
    // Opcode in
    input  wire [7:0] opcode,
    // Selects out
    output wire [2:0] reg_sel,
    output wire       ptr_sel
);
    // Low three bits name the bank register
    assign reg_sel = opcode[2:0];
    // Lowest bit names the pointer register
    assign ptr_sel = opcode[0];
endmodule // aid_fields
`default_nettype wire

// >>> src/aid_cyc_ctr.v
// Purpose: count out the execution cycles of one instruction
// Assumes: load only when idle or on the last cycle
// Notes:   a count of zero means idle
`include "aid_map.vh"
`timescale 1ns/100ps
`default_nettype none
module aid_cyc_ctr (
    // Clock and reset
    input  wire                  clk,
    input  wire                  nrst,
    // Load
    input  wire                  load,
    input  wire [`AID_CYC_W-1:0] cycles,
    // Status
    output wire                  busy,
    output wire                  last
);
    reg [`AID_CYC_W-1:0] cnt_r;   // Cycles still to run

    // Load wins, else count down to idle
    always @(posedge clk) begin
        if (!nrst) begin
            cnt_r <= `L0;
        end else if (load) begin
            cnt_r <= cycles;
        end else if (cnt_r != `L0) begin
            cnt_r <= cnt_r - `C1;
        end
    end

    assign busy = (cnt_r != `L0);
    assign last = (cnt_r == `C1);
endmodule // aid_cyc_ctr
`default_nettype wire

// >>> src/aid_decoder.v
// Purpose: decode opcodes, gather operand bytes, time execution
// Assumes: program memory runs on clk and holds a byte until taken
// Notes:   rows outside the covered groups come out as unknown
`include "aid_map.vh"
`timescale 1ns/100ps
`default_nettype none
module aid_decoder (
    // Clock and reset
    input  wire                  clk,
    input  wire                  nrst,
    // Program memory byte stream
    input  wire                  byte_valid,
    input  wire [7:0]            byte_data,
    output wire                  byte_ready,
    // Decoded instruction to datapath
    output wire                  insn_valid,
    output wire                  insn_last,
    output reg                   insn_known,
    output reg  [7:0]            insn_opcode,
    output reg  [`AID_FN_W-1:0]  insn_fn,
    output reg  [`AID_KD_W-1:0]  insn_src,
    output reg  [`AID_KD_W-1:0]  insn_dst,
    output reg  [`AID_LEN_W-1:0] insn_len,
    output reg  [`AID_CYC_W-1:0] insn_cycles,
    output reg  [2:0]            insn_reg_sel,
    output reg                   insn_ptr_sel,
    output reg  [7:0]            insn_op1,
    output reg  [7:0]            insn_op2
);
    // One-hot states
    localparam [2:0] S_IDLE = 3'h1;   // Waiting for an opcode
    localparam [2:0] S_OPER = 3'h2;   // Gathering operand bytes
    localparam [2:0] S_EXEC = 3'h4;   // Instruction presented

    reg  [2:0]            state_r;    // Current state
    reg  [2:0]            state_nxt;  // Next state
    reg  [`AID_LEN_W-1:0] rem_r;      // Operand bytes still owed
    reg                   idx_r;      // Next operand slot, 0 = first

    reg  [`AID_DEC_W-1:0] dec;        // Packed decode of byte_data
    wire                  dec_known;  // Opcode is in the table
    wire [2:0]            f_reg;      // Register select of byte
    wire                  f_ptr;      // Pointer select of byte
    wire                  take;       // Byte handshake this cycle
    wire                  load_exec;  // Enter execution this cycle
    wire                  ctr_busy;   // Execution counter running

    // Pack one table row; used by every decode branch
    function [`AID_DEC_W-1:0] pk;
        input [`AID_FN_W-1:0]  fn;
        input [`AID_KD_W-1:0]  src;
        input [`AID_KD_W-1:0]  dst;
        input [`AID_LEN_W-1:0] len;
        input [`AID_CYC_W-1:0] cyc;
        begin
            pk = {fn, src, dst, len, cyc};
        end
    endfunction

    // Unknown rows decode to a one-byte no-op so fetch keeps moving
    assign dec_known = (dec[`AID_DEC_W-1 -: `AID_FN_W] != `FN_NOP);

    // Select fields for register and pointer forms
    aid_fields u_fields (
        .opcode  (byte_data),
        .reg_sel (f_reg),
        .ptr_sel (f_ptr)
    );

    // Opcode table: singles first, then ranges of eight, then pairs
    always @* begin
        dec = pk(`FN_NOP, `K_NONE, `K_NONE, `L1, `C1);
        case (byte_data)
            // Arithmetic on direct and immediate bytes
            `OP_ADD_DIR:
                dec = pk(`FN_ADD, `K_DIR, `K_ACC, `L2, `C1);
            `OP_ADC_DIR:
                dec = pk(`FN_ADC, `K_DIR, `K_ACC, `L2, `C1);
            `OP_SBB_DIR:
                dec = pk(`FN_SBB, `K_DIR, `K_ACC, `L2, `C1);
            `OP_ADD_IMM:
                dec = pk(`FN_ADD, `K_IMM, `K_ACC, `L2, `C1);
            `OP_ADC_IMM:
                dec = pk(`FN_ADC, `K_IMM, `K_ACC, `L2, `C1);
            // Shared printed code keeps its subtract meaning
            `OP_SBB_IMM:
                dec = pk(`FN_SBB, `K_IMM, `K_ACC, `L2, `C1);
            // Logic into a direct byte
            `OP_ANL_DI:
                dec = pk(`FN_AND, `K_IMM, `K_DIR, `L3, `C2);
            `OP_ORL_DI:
                dec = pk(`FN_OR, `K_IMM, `K_DIR, `L3, `C2);
            `OP_XRL_DI:
                dec = pk(`FN_XOR, `K_IMM, `K_DIR, `L3, `C2);
            `OP_ANL_DA:
                dec = pk(`FN_AND, `K_ACC, `K_DIR, `L2, `C1);
            `OP_ORL_DA:
                dec = pk(`FN_OR, `K_ACC, `K_DIR, `L2, `C1);
            `OP_XRL_DA:
                dec = pk(`FN_XOR, `K_ACC, `K_DIR, `L2, `C1);
            // Logic into the accumulator
            `OP_ANL_DIR:
                dec = pk(`FN_AND, `K_DIR, `K_ACC, `L2, `C1);
            `OP_ORL_DIR:
                dec = pk(`FN_OR, `K_DIR, `K_ACC, `L2, `C1);
            `OP_XRL_DIR:
                dec = pk(`FN_XOR, `K_DIR, `K_ACC, `L2, `C1);
            `OP_ANL_IMM:
                dec = pk(`FN_AND, `K_IMM, `K_ACC, `L2, `C1);
            `OP_ORL_IMM:
                dec = pk(`FN_OR, `K_IMM, `K_ACC, `L2, `C1);
            `OP_XRL_IMM:
                dec = pk(`FN_XOR, `K_IMM, `K_ACC, `L2, `C1);
            // Rotates of the accumulator
            `OP_RL:
                dec = pk(`FN_RL, `K_ACC, `K_ACC, `L1, `C1);
            `OP_RLC:
                dec = pk(`FN_RLC, `K_ACC, `K_ACC, `L1, `C1);
            `OP_RR:
                dec = pk(`FN_RR, `K_ACC, `K_ACC, `L1, `C1);
            `OP_RRC:
                dec = pk(`FN_RRC, `K_ACC, `K_ACC, `L1, `C1);
            // Direct byte moves
            `OP_MOV_DD:
                dec = pk(`FN_MOV, `K_DIR, `K_DIR, `L3, `C2);
            `OP_MOV_DIMM:
                dec = pk(`FN_MOV, `K_IMM, `K_DIR, `L3, `C2);
            `OP_MOV_ADIR:
                dec = pk(`FN_MOV, `K_DIR, `K_ACC, `L2, `C1);
            `OP_MOV_DIRA:
                dec = pk(`FN_MOV, `K_ACC, `K_DIR, `L2, `C1);
            // Pointer and code space
            `OP_DPL:
                dec = pk(`FN_DPL, `K_IMM16, `K_DPR, `L3, `C2);
            `OP_CRD_DP:
                dec = pk(`FN_CRD, `K_CDP, `K_ACC, `L1, `C2);
            `OP_CRD_PC:
                dec = pk(`FN_CRD, `K_CPC, `K_ACC, `L1, `C2);
            // External data through the data pointer
            `OP_XRD_DP:
                dec = pk(`FN_XRD, `K_EXT16, `K_ACC, `L1, `C2);
            `OP_XWR_DP:
                dec = pk(`FN_XWR, `K_ACC, `K_EXT16, `L1, `C2);
            // Stack, then exchange with a direct byte
            `OP_PUSH:
                dec = pk(`FN_PUSH, `K_DIR, `K_STK, `L2, `C2);
            `OP_POP:
                dec = pk(`FN_POP, `K_STK, `K_DIR, `L2, `C2);
            `OP_XCH_DIR:
                dec = pk(`FN_XCH, `K_DIR, `K_ACC, `L2, `C1);
            default: begin
                // Bank register forms
                case (byte_data[7:3])
                    `RG_ADD:
                        dec = pk(`FN_ADD, `K_REG, `K_ACC, `L1, `C1);
                    `RG_ADC:
                        dec = pk(`FN_ADC, `K_REG, `K_ACC, `L1, `C1);
                    `RG_SBB:
                        dec = pk(`FN_SBB, `K_REG, `K_ACC, `L1, `C1);
                    `RG_ANL:
                        dec = pk(`FN_AND, `K_REG, `K_ACC, `L1, `C1);
                    `RG_ORL:
                        dec = pk(`FN_OR, `K_REG, `K_ACC, `L1, `C1);
                    `RG_XRL:
                        dec = pk(`FN_XOR, `K_REG, `K_ACC, `L1, `C1);
                    `RG_LD_DIR:
                        dec = pk(`FN_MOV, `K_DIR, `K_REG, `L2, `C2);
                    `RG_ST_DIR:
                        dec = pk(`FN_MOV, `K_REG, `K_DIR, `L2, `C2);
                    `RG_LD_IMM:
                        dec = pk(`FN_MOV, `K_IMM, `K_REG, `L2, `C1);
                    `RG_TO_A:
                        dec = pk(`FN_MOV, `K_REG, `K_ACC, `L1, `C1);
                    `RG_FROM_A:
                        dec = pk(`FN_MOV, `K_ACC, `K_REG, `L1, `C1);
                    `RG_XCH:
                        dec = pk(`FN_XCH, `K_REG, `K_ACC, `L1, `C1);
                    default: begin
                        // Indirect pointer forms
                        case (byte_data[7:1])
                            `PR_ADD:
                                dec = pk(`FN_ADD, `K_IND, `K_ACC,
                                         `L1, `C1);
                            `PR_ADC:
                                dec = pk(`FN_ADC, `K_IND, `K_ACC,
                                         `L1, `C1);
                            `PR_SBB:
                                dec = pk(`FN_SBB, `K_IND, `K_ACC,
                                         `L1, `C1);
                            `PR_ANL:
                                dec = pk(`FN_AND, `K_IND, `K_ACC,
                                         `L1, `C1);
                            `PR_ORL:
                                dec = pk(`FN_OR, `K_IND, `K_ACC,
                                         `L1, `C1);
                            `PR_XRL:
                                dec = pk(`FN_XOR, `K_IND, `K_ACC,
                                         `L1, `C1);
                            `PR_ST_A:
                                dec = pk(`FN_MOV, `K_ACC, `K_IND,
                                         `L1, `C1);
                            `PR_ST_DIR:
                                dec = pk(`FN_MOV, `K_DIR, `K_IND,
                                         `L2, `C2);
                            `PR_ST_IMM:
                                dec = pk(`FN_MOV, `K_IMM, `K_IND,
                                         `L2, `C1);
                            `PR_TO_DIR:
                                dec = pk(`FN_MOV, `K_IND, `K_DIR,
                                         `L2, `C2);
                            `PR_LD_A:
                                dec = pk(`FN_MOV, `K_IND, `K_ACC,
                                         `L1, `C1);
                            `PR_XRD:
                                dec = pk(`FN_XRD, `K_EXT8, `K_ACC,
                                         `L1, `C2);
                            `PR_XWR:
                                dec = pk(`FN_XWR, `K_ACC, `K_EXT8,
                                         `L1, `C2);
                            `PR_XCH:
                                dec = pk(`FN_XCH, `K_IND, `K_ACC,
                                         `L1, `C1);
                            default:
                                dec = pk(`FN_NOP, `K_NONE, `K_NONE,
                                         `L1, `C1);
                        endcase
                    end
                endcase
            end
        endcase
    end

    // Fetch accepts bytes only while not presenting an instruction
    assign byte_ready = state_r[0] | state_r[1];
    assign take       = byte_valid & byte_ready;

    // Start execution after the last owed byte
    assign load_exec = take &
        ((state_r[0] & (dec[`AID_CYC_W +: `AID_LEN_W] == `L1)) |
         (state_r[1] & (rem_r == `L1)));

    // Execution cycle timer
    aid_cyc_ctr u_ctr (
        .clk    (clk),
        .nrst   (nrst),
        .load   (load_exec),
        .cycles (insn_cycles_sel(state_r[0], dec, insn_cycles)),
        .busy   (ctr_busy),
        .last   (insn_last)
    );

    // Cycle count for the timer: fresh decode in idle, held otherwise
    function [`AID_CYC_W-1:0] insn_cycles_sel;
        input                  idle;
        input [`AID_DEC_W-1:0] d;
        input [`AID_CYC_W-1:0] held;
        begin
            insn_cycles_sel = idle ? d[`AID_CYC_W-1:0] : held;
        end
    endfunction

    // Instruction shown for exactly its cycle count
    assign insn_valid = state_r[2] & ctr_busy;

    // Next state
    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (take) begin
                    state_nxt = load_exec ? S_EXEC : S_OPER;
                end
            end
            S_OPER: begin
                if (load_exec) begin
                    state_nxt = S_EXEC;
                end
            end
            S_EXEC: begin
                // Back to fetch after the final cycle
                if (insn_last) begin
                    state_nxt = S_IDLE;
                end
            end
            default:
                state_nxt = S_IDLE;
        endcase
    end

    // State and operand bookkeeping
    always @(posedge clk) begin
        if (!nrst) begin
            state_r <= S_IDLE;
            rem_r   <= `L0;
            idx_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (take & state_r[0]) begin
                // Owed bytes are length less the opcode
                rem_r <= dec[`AID_CYC_W +: `AID_LEN_W] - `L1;
                idx_r <= 1'b0;
            end else if (take & state_r[1]) begin
                rem_r <= rem_r - `L1;
                idx_r <= 1'b1;
            end
        end
    end

    // Captured instruction fields, held through execution
    always @(posedge clk) begin
        if (!nrst) begin
            insn_known   <= 1'b0;
            insn_opcode  <= 8'h00;
            insn_fn      <= `FN_NOP;
            insn_src     <= `K_NONE;
            insn_dst     <= `K_NONE;
            insn_len     <= `L0;
            insn_cycles  <= `L0;
            insn_reg_sel <= 3'h0;
            insn_ptr_sel <= 1'b0;
            insn_op1     <= 8'h00;
            insn_op2     <= 8'h00;
        end else if (take & state_r[0]) begin
            insn_known   <= dec_known;
            insn_opcode  <= byte_data;
            {insn_fn, insn_src, insn_dst, insn_len, insn_cycles} <= dec;
            insn_reg_sel <= f_reg;
            insn_ptr_sel <= f_ptr;
            // Stale operands cleared so short forms show zero
            insn_op1     <= 8'h00;
            insn_op2     <= 8'h00;
        end else if (take & state_r[1]) begin
            // Operands kept in fetch order
            if (!idx_r) begin
                insn_op1 <= byte_data;
            end else begin
                insn_op2 <= byte_data;
            end
        end
    end
endmodule // aid_decoder
`default_nettype wire

// >>> bench/aid_chk_sva.sv
// Purpose: timing and field checks at the decoder ports
// Assumes: one clock, nrst synchronous and active low
// Notes:   bound to every decoder instance, watches its ports, inputs and outputs
`include "aid_map.vh"
`timescale 1ns/100ps
`default_nettype none
module aid_chk (
    // Clock, reset, byte stream
    input wire logic                  clk,
    input wire logic                  nrst,
    input wire logic                  byte_valid,
    input wire logic                  byte_ready,
    // Decode result
    input wire logic                  insn_valid,
    input wire logic                  insn_last,
    input wire logic [7:0]            insn_opcode,
    input wire logic [`AID_FN_W-1:0]  insn_fn,
    input wire logic [`AID_LEN_W-1:0] insn_len,
    input wire logic [`AID_CYC_W-1:0] insn_cycles,
    input wire logic [2:0]            insn_reg_sel,
    input wire logic                  insn_ptr_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Single cycle ends at once; a double one ends on its second cycle
    sequence end_one; insn_last ##1 !insn_valid; endsequence
    sequence end_two; !insn_last ##1 insn_last ##1 !insn_valid; endsequence
    one_cyc_a:
        assert property ($rose(insn_valid) && insn_cycles == `C1 |-> end_one)
        else $error("single-cycle span wrong");
    two_cyc_a:
        assert property ($rose(insn_valid) && insn_cycles == `C2 |-> end_two)
        else $error("two-cycle span wrong");
    answer_a:
        assert property ($rose(insn_valid)
            |-> $past(byte_valid) && $past(byte_ready))
        else $error("decode not right after last byte");
    sel_a:
        assert property (insn_valid |-> insn_reg_sel == insn_opcode[2:0]
            && insn_ptr_sel == insn_opcode[0])
        else $error("select bits wrong");
    crd_pc_a:
        assert property (insn_valid && insn_opcode == 8'h83
            |-> insn_fn == `FN_CRD && insn_cycles == `C2)
        else $error("relative code read wrong");
    ext_a:
        assert property (insn_valid && insn_fn inside {`FN_XRD, `FN_XWR}
            |-> insn_len == `L1 && insn_cycles == `C2)
        else $error("ext form wrong");
    data_pointer_a:
        assert property (insn_valid && insn_opcode == 8'h90
            |-> insn_fn == `FN_DPL && insn_len == `L3)
        else $error("pointer load wrong");
    stack_a:
        assert property (insn_valid && insn_fn inside {`FN_PUSH, `FN_POP}
            |-> insn_len == `L2 && insn_cycles == `C2)
        else $error("stack form wrong");
endmodule // aid_chk
bind aid_decoder aid_chk chk_u (
    .clk, .nrst, .byte_valid, .byte_ready, .insn_valid, .insn_last,
    .insn_opcode, .insn_fn, .insn_len, .insn_cycles, .insn_reg_sel,
    .insn_ptr_sel
);
`default_nettype wire

// >>> bench/aid_pmem.sv
// Purpose: program memory stand-in feeding bytes to the decoder
// Assumes: bench fills mem before reset is released and sets count as it releases reset
// Notes:   stall only delays a fresh offer, never a pending one
`timescale 1ns/100ps
`default_nettype none
module aid_pmem (
    // Clock, reset, bench control
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       stall,
    input  wire logic [7:0] count,
    // Byte stream
    input  wire logic       byte_ready,
    output var  logic       byte_valid,
    output wire logic [7:0] byte_data
);
    logic [7:0] mem [0:255]; // Program bytes
    logic [7:0] ptr_r;       // Next byte to offer
    logic [7:0] last_r;      // Last byte taken
    // Idle bus shows the inverse, so a stale byte is never mistaken
    assign byte_data = byte_valid ? mem[ptr_r] : ~last_r;
    // Offer bytes in order; an offer stands until taken
    always @(posedge clk) begin
        if (!nrst) begin
            ptr_r      <= 8'h00;
            last_r     <= 8'h00;
            byte_valid <= 1'b0;
        end else if (byte_valid && byte_ready) begin
            ptr_r      <= ptr_r + 8'h01;
            last_r     <= mem[ptr_r];
            byte_valid <= !stall && (ptr_r + 8'h01) < count;
        end else if (!byte_valid) begin
            byte_valid <= !stall && ptr_r < count;
        end
    end
endmodule // aid_pmem
`default_nettype wire

// >>> bench/tb.sv
// Purpose: run the decode table through the decoder
// Assumes: decoder keeps the hand-over timing contract
// Notes:   row = opcode, op code, bytes, cycles, source, target
`include "aid_map.vh"
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clk, nrst, stall;      // Clock, reset, memory stall
    logic [7:0]  count;                 // Program bytes loaded
    logic        pv = 1'b0;             // Valid at last edge
    logic [31:0] r;                     // Row under check
    int          miscompares, checks_done, k, n, i, vcnt;
    wire         byte_valid, byte_ready, insn_valid, insn_last;
    wire         insn_known;
    wire [7:0]   byte_data, insn_opcode, insn_op1, insn_op2;
    wire [`AID_FN_W-1:0]  insn_fn;
    wire [`AID_KD_W-1:0]  insn_src, insn_dst;
    wire [`AID_LEN_W-1:0] insn_len;
    wire [`AID_CYC_W-1:0] insn_cycles;
    wire [2:0]   insn_reg_sel;
    wire         insn_ptr_sel;
    logic [31:0] rows [$] = '{
        32'h5304_3253, 32'h4305_3253, 32'h6306_3253,
        32'h850B_3233, 32'h2801_1121, 32'h3F02_1121,
        32'h9803_1121, 32'h9603_1141, 32'h2701_1141,
        32'h3602_1141, 32'h2501_2131, 32'h3502_2131,
        32'h9503_2131, 32'h2401_2151, 32'h3402_2151,
        32'h9403_2151, 32'h5204_2113, 32'h4205_2113,
        32'h6206_2113, 32'h5804_1121, 32'h4F05_1121,
        32'h6806_1121, 32'h5704_1141, 32'h4605_1141,
        32'h6606_1141, 32'h5504_2131, 32'h4505_2131,
        32'h6506_2131, 32'h5404_2151, 32'h4405_2151,
        32'h6406_2151, 32'h2307_1111, 32'h3308_1111,
        32'h0309_1111, 32'h130A_1111, 32'hA80B_2232,
        32'h8F0B_2223, 32'h7F0B_2152, 32'hE80B_1121,
        32'hF80B_1112, 32'h750B_3253, 32'hE50B_2131,
        32'hF50B_2113, 32'hF60B_1114, 32'hA60B_2234,
        32'h770B_2154, 32'h860B_2243, 32'hE70B_1141,
        32'h9012_32BA, 32'h930F_1261, 32'hE010_1281,
        32'hE310_1271, 32'hF011_1218, 32'hF211_1217,
        32'hC00D_2239, 32'hD00E_2293, 32'hC80C_1121,
        32'hC50C_2131, 32'hC70C_1141, 32'h830F_12C1,
        32'h0400_1100};
    aid_decoder dut_u (
        .clk, .nrst, .byte_valid, .byte_data, .byte_ready, .insn_valid,
        .insn_last, .insn_known, .insn_opcode, .insn_fn, .insn_src,
        .insn_dst, .insn_len, .insn_cycles, .insn_reg_sel, .insn_ptr_sel,
        .insn_op1, .insn_op2);
    aid_pmem pm_u (
        .clk, .nrst, .stall, .count, .byte_ready, .byte_valid, .byte_data);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Compare one value, count it, report a miss
    task automatic chk(input string nm, input logic [7:0] e, g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim;
        if (miscompares == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Each new decode against the next row; span checked at its end
    always @(posedge clk) begin
        pv   <= insn_valid;
        vcnt <= insn_valid ? vcnt + 1 : 0;
        if (nrst && insn_valid && !pv) begin
            r = rows[k];
            chk("opcode", r[31:24], insn_opcode);
            chk("fn", r[23:16], 8'(insn_fn));
            chk("known", 8'(r[23:16] != 8'h00), 8'(insn_known));
            chk("len", 8'(r[15:12]), 8'(insn_len));
            chk("cycles", 8'(r[11:8]), 8'(insn_cycles));
            chk("src", 8'(r[7:4]), 8'(insn_src));
            chk("dst", 8'(r[3:0]), 8'(insn_dst));
            chk("op1", r[15:12] > 1 ? 8'hA5 : 8'h00, insn_op1);
            chk("op2", r[15:12] > 2 ? 8'h3C : 8'h00, insn_op2);
        end
        if (nrst && insn_last) begin
            chk("span", 8'(r[11:8]), 8'(vcnt + 1));
            k = k + 1;
        end
    end
    initial begin
        nrst  <= 1'b0;
        stall <= 1'b0;
        count <= 8'h00;
        // Operand bytes A5 then 3C; the next opcode overwrites spares
        foreach (rows[j]) begin
            pm_u.mem[n]     = rows[j][31:24];
            pm_u.mem[n + 1] = 8'hA5;
            pm_u.mem[n + 2] = 8'h3C;
            n = n + 32'(rows[j][15:12]);
        end
        repeat (3) @(posedge clk);
        nrst  <= 1'b1;
        count <= 8'(n);
        // Table run, memory stalling now and then
        for (i = 0; i < 1500 && k < rows.size(); i++) begin
            @(posedge clk);
            stall <= (i % 5) == 2;
        end
        chk("rows", 8'(rows.size()), 8'(k));
        // Replay, then reset in the first cycle of the two-cycle form
        stall <= 1'b0;
        nrst  <= 1'b0;
        k = 0;
        @(posedge clk);
        nrst <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            #1;
            i++;
        end while (!(byte_valid && byte_ready && byte_data == 8'h3C)
                   && i < 50);
        @(posedge clk);
        nrst  <= 1'b0;
        count <= 8'h00;
        @(posedge clk);
        #1;
        chk("valid", 8'h00, 8'(insn_valid));
        chk("ready", 8'h01, 8'(byte_ready));
        chk("len", 8'h00, 8'(insn_len));
        chk("last", 8'h00, 8'(insn_last));
        end_sim;
    end
    // Hang guard, well beyond the table run
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        end_sim;
    end
endmodule // tb
`default_nettype wire
